// *** bcrt_pkg.sv ***
// Package of constants for the board clock, reset and bus timeout block.
package bcrt_pkg;
   // Core clock is 250 MHz; the oscillator time base is emulated by enables.
   localparam int CLK_PERIOD_PS = 4000;
   localparam int OSC_PERIOD_PS = 125000;
   // Enable divisors: 8 MHz from the core clock, 1 MHz from the 8 MHz ticks.
   localparam int DIV_8M = OSC_PERIOD_PS / CLK_PERIOD_PS;
   localparam logic [5:0] DIV_8M_LAST = 6'(DIV_8M - 1);
   localparam logic [2:0] DIV_1M_LAST = 3'h7;
   // Bus timeout, roughly ten microseconds, counted in 1 MHz ticks.
   localparam int TIMEOUT_US = 10;
   localparam logic [3:0] TIMEOUT_TICKS = 4'(TIMEOUT_US);
   // Power-up reset duration in 1 MHz ticks.
   localparam int PWRUP_US = 100;
   localparam logic [7:0] PWRUP_TICKS = 8'(PWRUP_US);
   // Button reset pulse length in 1 MHz ticks.
   localparam logic [7:0] BTN_TICKS = 8'h10;
   // Segment decodes on address bits 23:16.
   localparam logic [7:0] SEG_FIRST = 8'h02;
   localparam logic [7:0] SEG_SYNC = 8'h03;
   localparam logic [7:0] SEG_UPPER_BASE = 8'h04;
   localparam int SEG_UPPER_NUM = 4;
   // Interrupt levels (active-low priority code out is inverted level).
   localparam logic [2:0] IPL_ABORT = 3'h7;
   localparam logic [2:0] IPL_LEGACY = 3'h4;
   localparam logic [7:0] LEGACY_VECTOR = 8'h1c;
endpackage

// *** bcrt_top.sv ***
// Clock enables, bus timeout, reset sequencing, abort and segment decodes.
// Contract
// - Derive 4 and 1 MHz from 8 MHz
// - Processor clock runs at 4 MHz
// - Unanswered cycle ends in bus error
// - ROM writes, unused locations get no acknowledge
// - Power-up asserts reset and power-on clear
// - Reset for processor; clear for others
// - Button asserts reset only, not clear
// - Halt asserted at power-up, drives indicator
// - Processor fetches vectors after reset
// - Abort button raises level 7 interrupt
// - Abort never asserts any reset
// - Upper enables low when decoded with strobe
// - Separate enable for synchronous peripheral page
// - Five enables decode listed 64K segments
// - Page selects valid input, enable after strobes
// - Legacy interrupt gives level 4 autovector
`timescale 1ns/10ps
module bcrt_top
   import bcrt_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [23:16] addr_hi,
   input wire logic address_strobe_n,
   input wire logic lower_byte_strobe_n,
   input wire logic valid_mem_addr_n,
   input wire logic transfer_ack_n,
   input wire logic [2:0] func_code,
   input wire logic reset_button,
   input wire logic abort_button,
   input wire logic legacy_irq_n,
   output logic clk8_en,
   output logic clk4_en,
   output logic clk1_en,
   output logic cpu_clk,
   output logic bus_error_n,
   output logic cpu_reset_n,
   output logic power_on_clear_n,
   output logic halt_n,
   output logic halt_led,
   output logic [2:0] ipl_n,
   output logic periph_addr_valid_n,
   output logic segment_enable_first_n,
   output logic [SEG_UPPER_NUM-1:0] segment_enable_upper_n,
   output logic sync_page_select,
   output logic [7:0] autovector
);

   ////////////////////////////////////////////////////////////////////////
   logic [5:0] pre_cnt_reg;
   logic tick8;
   logic [2:0] div_reg;

   // Prescaler models the 8 MHz oscillator as a one-cycle enable.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_cnt_reg <= 6'h00;
      end else if (pre_cnt_reg == DIV_8M_LAST) begin
         pre_cnt_reg <= 6'h00;
      end else begin
         pre_cnt_reg <= pre_cnt_reg + 6'h01;
      end
   end
   assign tick8 = (pre_cnt_reg == DIV_8M_LAST);

   // Binary counter off the 8 MHz time base gives 4 and 1 MHz.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_reg <= 3'h0;
         clk8_en <= 1'b0;
         clk4_en <= 1'b0;
         clk1_en <= 1'b0;
         cpu_clk <= 1'b0;
      end else begin
         clk8_en <= tick8;
         clk4_en <= tick8 && div_reg[0];
         clk1_en <= tick8 && (div_reg == DIV_1M_LAST);
         if (tick8) begin
            div_reg <= div_reg + 3'h1;
            cpu_clk <= ~div_reg[0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic [3:0] to_cnt_reg;
   logic as_prev_reg;
   logic cycle_start;

   assign cycle_start = as_prev_reg && !address_strobe_n;

   // Timeout counter restarts on each strobe edge; the 1 MHz base makes the
   // interval 9 to 10 us, which is close enough for a watchdog.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         as_prev_reg <= 1'b1;
         to_cnt_reg <= 4'h0;
         bus_error_n <= 1'b1;
      end else begin
         as_prev_reg <= address_strobe_n;
         if (address_strobe_n || cycle_start) begin
            to_cnt_reg <= 4'h0;
            bus_error_n <= 1'b1;
         end else if (!transfer_ack_n || !periph_addr_valid_n) begin
            to_cnt_reg <= 4'h0; // Answered cycles never time out.
         end else if (clk1_en && to_cnt_reg != TIMEOUT_TICKS) begin
            to_cnt_reg <= to_cnt_reg + 4'h1;
         end else if (to_cnt_reg == TIMEOUT_TICKS) begin
            bus_error_n <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic [7:0] rst_cnt_reg;
   logic pwrup_reg;
   logic btn_reg;

   // Power-up timer holds reset, clear and halt; button holds reset only.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_cnt_reg <= 8'h00;
         pwrup_reg <= 1'b1;
         btn_reg <= 1'b0;
      end else if (pwrup_reg) begin
         if (clk1_en) begin
            rst_cnt_reg <= rst_cnt_reg + 8'h01;
         end
         if (rst_cnt_reg == PWRUP_TICKS) begin
            pwrup_reg <= 1'b0;
            rst_cnt_reg <= 8'h00;
         end
      end else if (reset_button) begin
         btn_reg <= 1'b1;
         rst_cnt_reg <= 8'h00;
      end else if (btn_reg) begin
         if (clk1_en) begin
            rst_cnt_reg <= rst_cnt_reg + 8'h01;
         end
         if (rst_cnt_reg == BTN_TICKS) begin
            btn_reg <= 1'b0;
         end
      end
   end

   // Abort plays no part here, so an abort keeps registers and memory.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cpu_reset_n <= 1'b0;
         power_on_clear_n <= 1'b0;
         halt_n <= 1'b0;
         halt_led <= 1'b1;
      end else begin
         cpu_reset_n <= !(pwrup_reg || btn_reg || reset_button);
         power_on_clear_n <= !pwrup_reg;
         halt_n <= !pwrup_reg;
         halt_led <= pwrup_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic iack;
   logic [2:0] ack_level;

   assign iack = (func_code == 3'h7) && !address_strobe_n;
   assign ack_level = addr_hi[19:17];

   // Abort outranks the legacy request; a button press is a level hold.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ipl_n <= 3'h7;
      end else if (abort_button) begin
         ipl_n <= ~IPL_ABORT;
      end else if (!legacy_irq_n) begin
         ipl_n <= ~IPL_LEGACY;
      end else begin
         ipl_n <= 3'h7;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Segment decodes; valid only while the address strobe is low.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         segment_enable_first_n <= 1'b1;
         sync_page_select <= 1'b0;
         periph_addr_valid_n <= 1'b1;
         autovector <= 8'h00;
      end else begin
         segment_enable_first_n <= !(!address_strobe_n && addr_hi == SEG_FIRST);
         // Page decode asks for a synchronous cycle first.
         periph_addr_valid_n <= !(!address_strobe_n && !iack && addr_hi == SEG_SYNC
            || iack && (ack_level == IPL_LEGACY || ack_level == IPL_ABORT));
         sync_page_select <= !address_strobe_n && addr_hi == SEG_SYNC
            && !valid_mem_addr_n && !lower_byte_strobe_n;
         autovector <= (iack && ack_level == IPL_LEGACY) ? LEGACY_VECTOR : 8'h00;
      end
   end

   wire [SEG_UPPER_NUM-1:0] seg_hit;

   genvar gi;
   generate
      for (gi = 0; gi < SEG_UPPER_NUM; gi++) begin : g_seg
         // Ascending 64K segments above the synchronous page.
         assign seg_hit[gi] = !address_strobe_n && addr_hi == SEG_UPPER_BASE + 8'(gi);
      end
   endgenerate

   // One register for all upper enables, so no bit has a second writer.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         segment_enable_upper_n <= {SEG_UPPER_NUM{1'b1}};
      end else begin
         segment_enable_upper_n <= ~seg_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   property p_clear_only_powerup;
      @(posedge clk) disable iff (!rst_b)
      !power_on_clear_n |-> !cpu_reset_n;
   endproperty
   a_clear_only_powerup: assert property (p_clear_only_powerup) else $error("clear without reset");

   property p_button_no_clear;
      @(posedge clk) disable iff (!rst_b)
      (!pwrup_reg && reset_button) |=> power_on_clear_n && !cpu_reset_n;
   endproperty
   a_button_no_clear: assert property (p_button_no_clear) else $error("button touched clear");

   property p_abort_level;
      @(posedge clk) disable iff (!rst_b)
      abort_button |=> ipl_n == 3'h0;
   endproperty
   a_abort_level: assert property (p_abort_level) else $error("abort level wrong");

   property p_abort_no_reset;
      @(posedge clk) disable iff (!rst_b)
      (abort_button && !reset_button && !pwrup_reg && !btn_reg) |=> cpu_reset_n;
   endproperty
   a_abort_no_reset: assert property (p_abort_no_reset) else $error("abort caused reset");

   property p_seg_first;
      @(posedge clk) disable iff (!rst_b)
      (!address_strobe_n && addr_hi == 8'h02) |=> !segment_enable_first_n;
   endproperty
   a_seg_first: assert property (p_seg_first) else $error("first segment missed");

   property p_seg_idle;
      @(posedge clk) disable iff (!rst_b)
      address_strobe_n |=> segment_enable_first_n && (&segment_enable_upper_n) && !sync_page_select;
   endproperty
   a_seg_idle: assert property (p_seg_idle) else $error("enable without strobe");

   property p_berr_clear;
      @(posedge clk) disable iff (!rst_b)
      address_strobe_n |=> bus_error_n;
   endproperty
   a_berr_clear: assert property (p_berr_clear) else $error("bus error outlived cycle");

   property p_berr_ack;
      @(posedge clk) disable iff (!rst_b)
      (!address_strobe_n && !transfer_ack_n && bus_error_n) |=> bus_error_n;
   endproperty
   a_berr_ack: assert property (p_berr_ack) else $error("acked cycle errored");

   property p_powerup_halt;
      @(posedge clk) disable iff (!rst_b)
      pwrup_reg |=> !halt_n && halt_led;
   endproperty
   a_powerup_halt: assert property (p_powerup_halt) else $error("halt missing at power-up");

   property p_clk4_on_tick;
      @(posedge clk) disable iff (!rst_b)
      clk4_en |-> clk8_en;
   endproperty
   a_clk4_on_tick: assert property (p_clk4_on_tick) else $error("4 MHz enable off the 8 MHz tick");

   property p_clk1_on_tick;
      @(posedge clk) disable iff (!rst_b)
      clk1_en |-> clk4_en;
   endproperty
   a_clk1_on_tick: assert property (p_clk1_on_tick) else $error("1 MHz enable off the 4 MHz tick");

   property p_cpu_clk_rate;
      @(posedge clk) disable iff (!rst_b)
      $changed(cpu_clk) == clk8_en;
   endproperty
   a_cpu_clk_rate: assert property (p_cpu_clk_rate) else $error("processor clock off the 8 MHz tick");

   property p_berr_full_count;
      @(posedge clk) disable iff (!rst_b)
      $fell(bus_error_n) |-> to_cnt_reg == TIMEOUT_TICKS;
   endproperty
   a_berr_full_count: assert property (p_berr_full_count) else $error("bus error before full count");

   property p_btn_holds_reset;
      @(posedge clk) disable iff (!rst_b)
      reset_button |=> !cpu_reset_n;
   endproperty
   a_btn_holds_reset: assert property (p_btn_holds_reset) else $error("button did not reset");

   property p_legacy_level;
      @(posedge clk) disable iff (!rst_b)
      (!legacy_irq_n && !abort_button) |=> ipl_n == ~IPL_LEGACY;
   endproperty
   a_legacy_level: assert property (p_legacy_level) else $error("legacy level wrong");

   property p_sync_after_valid;
      @(posedge clk) disable iff (!rst_b)
      sync_page_select |-> !periph_addr_valid_n;
   endproperty
   a_sync_after_valid: assert property (p_sync_after_valid) else $error("page enable without valid");
endmodule

// *** bcrt_cpu_model.sv ***
// Behavioural processor bus master facing the block.
`timescale 1ns/10ps
module bcrt_cpu_model (
   input wire logic clk,
   output logic [7:0] addr_hi,
   output logic address_strobe_n,
   output logic transfer_ack_n
);
   // Idle bus at time zero.
   initial begin
      addr_hi = 8'h00;
      address_strobe_n = 1'b1;
      transfer_ack_n = 1'b1;
   end
   // Opens a cycle; add-on targets stay in free segments.
   task automatic start(input logic [7:0] a);
      @(posedge clk);
      addr_hi <= a;
      address_strobe_n <= 1'b0;
   endtask
   // A responder answers the cycle.
   task automatic ack();
      @(posedge clk);
      transfer_ack_n <= 1'b0;
   endtask
   // Released address shows its inverse so no stale decode can pass.
   task automatic stop();
      @(posedge clk);
      address_strobe_n <= 1'b1;
      transfer_ack_n <= 1'b1;
      addr_hi <= ~addr_hi;
   endtask
endmodule

// *** bcrt_top_tb.sv ***
// Self-checking bench for the clock, reset and timeout block.
`timescale 1ns/10ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fail_count++; \
   $display("[FAIL] %s exp %h got %h", n, e, a); end end
module bcrt_top_tb;
   import bcrt_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, lds_n = 1'b1, vma_n = 1'b1;
   logic rst_btn = 1'b0, abort = 1'b0, irq_n = 1'b1;
   logic [2:0] fc = 3'h0;
   logic [7:0] a, av;
   logic as_n, ack_n, c8, c4, c1, cc, berr_n, crst_n, por_n, halt_n, led, pav_n, s1_n, sps;
   logic [2:0] ipl_n;
   logic [3:0] su_n;
   int fail_count = 0, compares = 0;
   ////////////////////////////////////////////////////////////////
   // Clock at 250 MHz.
   always #2 clk = ~clk;
   bcrt_cpu_model bcrt_cpu_model_i (.clk(clk), .addr_hi(a), .address_strobe_n(as_n), .transfer_ack_n(ack_n));
   bcrt_top bcrt_top_i (.clk(clk), .rst_b(rst_b), .addr_hi(a), .address_strobe_n(as_n),
      .lower_byte_strobe_n(lds_n), .valid_mem_addr_n(vma_n), .transfer_ack_n(ack_n), .func_code(fc),
      .reset_button(rst_btn), .abort_button(abort), .legacy_irq_n(irq_n), .clk8_en(c8), .clk4_en(c4),
      .clk1_en(c1), .cpu_clk(cc), .bus_error_n(berr_n), .cpu_reset_n(crst_n), .power_on_clear_n(por_n),
      .halt_n(halt_n), .halt_led(led), .ipl_n(ipl_n), .periph_addr_valid_n(pav_n),
      .segment_enable_first_n(s1_n), .segment_enable_upper_n(su_n), .sync_page_select(sps), .autovector(av));
   ////////////////////////////////////////////////////////////////
   // Core clock cycles in one 1 MHz period; the divisor does not divide evenly.
   localparam int US_CYC = 8 * DIV_8M;
   // Counts cycles until a reset output releases, with a bound.
   task automatic wait_rel(output int n, input int lim);
      n = 0;
      while (crst_n !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic t_pwrup();
      int n;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (100) @(negedge clk);
      `CHK("rst", 1'b0, crst_n)
      `CHK("por", 1'b0, por_n)
      `CHK("led", 1'b1, led)
      `CHK("halt", 1'b0, halt_n)
      wait_rel(n, 27000);
      // The wait starts 100 cycles after release, so the count falls a little short.
      `CHK("pwrup_len", 1'b1, n >= int'(PWRUP_TICKS) * US_CYC - 200 && n <= int'(PWRUP_TICKS) * US_CYC)
      `CHK("por_rel", 1'b1, por_n)
      `CHK("led_off", 1'b0, led)
      `CHK("halt_off", 1'b1, halt_n)
      $display("done power-up");
   endtask
   // Pulses over two 1 MHz periods, aligned on a 1 MHz pulse so the counts are exact.
   task automatic t_clk();
      int n8, n4, n1, nt;
      logic p;
      n8 = 0;
      n4 = 0;
      n1 = 0;
      nt = 0;
      while (c1 !== 1'b1) @(negedge clk);
      p = cc;
      repeat (2 * US_CYC) begin
         @(negedge clk);
         n8 += c8;
         n4 += c4;
         n1 += c1;
         nt += (cc != p);
         p = cc;
      end
      `CHK("n8", 16, n8)
      `CHK("n4", 8, n4)
      `CHK("n1", 2, n1)
      `CHK("cpu_clk", 16, nt)
      $display("done clocks");
   endtask
   // Each segment decodes alone and only under the strobe.
   task automatic t_seg();
      logic [7:0] t[5] = '{8'h02, 8'h04, 8'h05, 8'h06, 8'h07};
      foreach (t[i]) begin
         bcrt_cpu_model_i.start(t[i]);
         repeat (2) @(negedge clk);
         `CHK("first", (i != 0), s1_n)
         `CHK("upper", (i == 0) ? 4'hf : ~(4'h1 << (i - 1)), su_n)
         bcrt_cpu_model_i.ack();
         bcrt_cpu_model_i.stop();
         repeat (2) @(negedge clk);
         `CHK("idle", 5'h1f, {s1_n, su_n})
      end
      $display("done segments");
   endtask
   // Page select needs the address strobe first, then the valid input and lower strobe together.
   task automatic t_sync();
      bcrt_cpu_model_i.start(8'h03);
      repeat (2) @(negedge clk);
      `CHK("pav", 1'b0, pav_n)
      `CHK("sps0", 1'b0, sps)
      @(posedge clk) {vma_n, lds_n} <= 2'b00;
      repeat (2) @(negedge clk);
      `CHK("sps1", 1'b1, sps)
      @(posedge clk) {vma_n, lds_n} <= 2'b11;
      bcrt_cpu_model_i.stop();
      $display("done sync page");
   endtask
   // Unused location times out; back-to-back unanswered 8 us cycles never do.
   task automatic t_tmo();
      int n;
      bcrt_cpu_model_i.start(8'h0c);
      n = 0;
      while (berr_n !== 1'b0 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      `CHK("berr_time", 1'b1, n >= (TIMEOUT_US - 1) * US_CYC && n <= TIMEOUT_US * US_CYC + 4)
      bcrt_cpu_model_i.stop();
      repeat (2) @(negedge clk);
      `CHK("berr_clr", 1'b1, berr_n)
      // Without an answer only the strobe edge restarts the count.
      repeat (2) begin
         bcrt_cpu_model_i.start(8'h00);
         repeat (2000) @(negedge clk);
         `CHK("no_berr", 1'b1, berr_n)
         bcrt_cpu_model_i.stop();
      end
      $display("done timeout");
   endtask
   // Legacy level 4 with autovector, then abort without any reset.
   task automatic t_irq();
      @(posedge clk) irq_n <= 1'b0;
      repeat (2) @(negedge clk);
      `CHK("ipl4", 3'h3, ipl_n)
      @(posedge clk) fc <= 3'h7;
      bcrt_cpu_model_i.start(8'h08);
      repeat (2) @(negedge clk);
      `CHK("iack_pav", 1'b0, pav_n)
      `CHK("vector", 8'h1c, av)
      bcrt_cpu_model_i.stop();
      @(posedge clk) {fc, irq_n, abort} <= 5'h03;
      repeat (300) @(negedge clk);
      `CHK("ipl7", 3'h0, ipl_n)
      `CHK("no_rst", 2'b11, {crst_n, por_n})
      @(posedge clk) abort <= 1'b0;
      // A level 7 acknowledge is autovectored too, with no legacy vector.
      @(posedge clk) fc <= 3'h7;
      bcrt_cpu_model_i.start(8'h0e);
      repeat (2) @(negedge clk);
      `CHK("iack7_pav", 1'b0, pav_n)
      `CHK("vector7", 8'h00, av)
      bcrt_cpu_model_i.stop();
      @(posedge clk) fc <= 3'h0;
      repeat (2) @(negedge clk);
      `CHK("iack_end", 1'b1, pav_n)
      $display("done interrupts");
   endtask
   // Button resets the processor only, then releases after the hold time.
   task automatic t_btn();
      int n;
      @(posedge clk) rst_btn <= 1'b1;
      repeat (4) @(negedge clk);
      `CHK("btn_rst", 2'b01, {crst_n, por_n})
      @(posedge clk) rst_btn <= 1'b0;
      wait_rel(n, 5000);
      `CHK("btn_len", 1'b1, n >= (int'(BTN_TICKS) - 1) * US_CYC)
      `CHK("btn_rel", 2'b11, {crst_n, por_n})
      $display("done button");
   endtask
   task automatic summarize();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // Main sequence; the run needs about 40000 cycles.
   initial begin
      t_pwrup(); t_clk(); t_seg(); t_sync(); t_tmo(); t_irq(); t_btn();
      summarize();
   end
   // Watchdog well past the expected run length.
   initial begin
      #(70000 * 4);
      fail_count++;
      summarize();
   end
endmodule
